// File: rtl/vram_pkg.sv
package vram_pkg;

    // ========================================================================
    // Register map. Printed offsets are not all multiples of four, so they
    // are register indices and the byte address is four times the index.
    // ========================================================================
    localparam logic [7:0] VRAM_IDX_EMERG     = 8'h4F;
    localparam logic [7:0] VRAM_IDX_MUTE_CTRL = 8'h50;
    localparam logic [7:0] VRAM_IDX_MUTE_TIME = 8'h51;
    localparam logic [7:0] VRAM_IDX_STATUS    = 8'h52;
    localparam logic [7:0] VRAM_IDX_FAULT     = 8'h5A;

    localparam logic [7:0] VRAM_EMERG_RST     = 8'h30;
    localparam logic [7:0] VRAM_MUTE_CTRL_RST = 8'h07;
    localparam logic [7:0] VRAM_MUTE_TIME_RST = 8'h00;
    localparam logic [7:0] VRAM_VOL_RST       = 8'h30;

    localparam int VRAM_SPEED_MSB  = 7;
    localparam int VRAM_SPEED_LSB  = 6;
    localparam int VRAM_STEP_MSB   = 5;
    localparam int VRAM_STEP_LSB   = 4;
    localparam int VRAM_EN_LEFT    = 0;
    localparam int VRAM_EN_RIGHT   = 1;
    localparam int VRAM_LINK       = 2;
    localparam int VRAM_TLEFT_MSB  = 6;
    localparam int VRAM_TLEFT_LSB  = 4;
    localparam int VRAM_TRIGHT_MSB = 2;
    localparam int VRAM_TRIGHT_LSB = 0;

    // Field masks: reserved bits of the control registers read as zero.
    localparam logic [7:0] VRAM_EMERG_MASK     = 8'hF0;
    localparam logic [7:0] VRAM_MUTE_CTRL_MASK = 8'h07;
    localparam logic [7:0] VRAM_MUTE_TIME_MASK = 8'h77;

    localparam logic [1:0] VRAM_SPEED_INSTANT = 2'h3;
    localparam logic [7:0] VRAM_VOL_MUTE      = 8'hFF;

    // ========================================================================
    // Silence durations at 96 kHz, in microseconds, and sample counts.
    // ========================================================================
    localparam int VRAM_FS_HZ = 96000;
    localparam int VRAM_DUR_US [8] = '{11500, 53000, 106500, 266500,
                                       535000, 1065000, 2665000, 5330000};
    localparam int VRAM_CNT_W = 20;

    function automatic logic [VRAM_CNT_W-1:0] vram_dur_samples(
        input logic [2:0] code
    );
        longint n;
        n = (longint'(VRAM_DUR_US[code]) * VRAM_FS_HZ) / 1000000;
        return n[VRAM_CNT_W-1:0];
    endfunction

endpackage

// File: rtl/vram_silence.sv
`timescale 1ns/100ps

// ============================================================================
// One channel's zero-run counter and silence flag.
// ============================================================================
module vram_silence
    import vram_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        sample_stb,
    input  wire logic        sample_zero,
    input  wire logic [2:0]  dur_code,
    output logic             silent
);

    logic [VRAM_CNT_W-1:0] run_r;
    logic [VRAM_CNT_W-1:0] limit;

    assign limit = vram_dur_samples(dur_code);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= '0;
        end else if (ce && sample_stb) begin
            if (!sample_zero) begin
                run_r <= '0;
            end else if (run_r < limit) begin
                run_r <= run_r + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            silent <= 1'b0;
        end else if (ce && sample_stb) begin
            silent <= sample_zero && (run_r + 1'b1 >= limit);
        end
    end

endmodule

// File: rtl/vram_top.sv
// Register access over APB was decided locally.
`timescale 1ns/100ps

//
// Function
// - Emergency updates come every 1, 2 or 4 samples for speed codes 0-2, and code 3 mutes at once.
// - Each emergency update lowers volume by 8, 4, 2 or 1 half-dB codes for step codes 0-3.
// - A clock fault or power loss uses the emergency ramp, not the normal soft-mute ramp.
// - The emergency ramp register resets to 0x30 with its low four bits zero.
// - Control bit 0 enables auto-mute of the left channel.
// - Control bit 1 enables auto-mute of the right channel.
// - With control bit 2 clear each channel mutes on its own silence.
// - The auto-mute control register resets to 0x07.
// - The left channel is silent after a run of zero samples set by its 3-bit duration code.
// - The right channel uses its own 3-bit duration code with the same eight durations.
// - Durations count a fixed number of samples, exact at 96 kHz, scaling with other rates.
// - The duration register resets to zero with reserved bits 7 and 3 reading zero.
// - Volume is an 8-bit code in half-dB steps from +24 dB, with 0xFF meaning mute.
//
module vram_top
    import vram_pkg::*;
#(
    parameter int SAMPLE_W = 24
)(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                clk_en,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                sample_stb,
    input  wire logic [SAMPLE_W-1:0] sample_left,
    input  wire logic [SAMPLE_W-1:0] sample_right,
    input  wire logic                clock_fault,
    input  wire logic                power_loss,
    input  wire logic [7:0]          normal_volume,
    output logic      [7:0]          volume_code,
    output logic                     emergency_active,
    output logic                     mute_left,
    output logic                     mute_right
);

    // ========================================================================
    // Fault pin synchronisers.
    // ========================================================================
    logic [1:0] fault_meta_r;
    logic [1:0] fault_sync_r;
    logic       fault;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_meta_r <= 2'h0;
            fault_sync_r <= 2'h0;
        end else if (clk_en) begin
            fault_meta_r <= {clock_fault, power_loss};
            fault_sync_r <= fault_meta_r;
        end
    end

    assign fault = |fault_sync_r;

    // ========================================================================
    // APB register file.
    // ========================================================================
    logic [7:0] emerg_r;
    logic [7:0] mute_ctrl_r;
    logic [7:0] mute_time_r;
    logic [7:0] idx;
    logic       addr_ok;
    logic       wr_en;

    assign idx     = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                     (idx == VRAM_IDX_EMERG || idx == VRAM_IDX_MUTE_CTRL ||
                      idx == VRAM_IDX_MUTE_TIME || idx == VRAM_IDX_STATUS);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en   = clk_en && psel && penable && pwrite && addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emerg_r <= VRAM_EMERG_RST;
        end else if (wr_en && idx == VRAM_IDX_EMERG) begin
            emerg_r <= pwdata[7:0] & VRAM_EMERG_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mute_ctrl_r <= VRAM_MUTE_CTRL_RST;
        end else if (wr_en && idx == VRAM_IDX_MUTE_CTRL) begin
            mute_ctrl_r <= pwdata[7:0] & VRAM_MUTE_CTRL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mute_time_r <= VRAM_MUTE_TIME_RST;
        end else if (wr_en && idx == VRAM_IDX_MUTE_TIME) begin
            mute_time_r <= pwdata[7:0] & VRAM_MUTE_TIME_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (clk_en && psel && !penable && !pwrite) begin
            case (idx)
                VRAM_IDX_EMERG:     prdata <= {24'h0, emerg_r};
                VRAM_IDX_MUTE_CTRL: prdata <= {24'h0, mute_ctrl_r};
                VRAM_IDX_MUTE_TIME: prdata <= {24'h0, mute_time_r};
                VRAM_IDX_STATUS:    prdata <= {24'h0, emergency_active,
                                               mute_right, mute_left,
                                               5'h00};
                default:            prdata <= 32'h0;
            endcase
        end
    end

    // ========================================================================
    // Silence detection and auto-mute.
    // ========================================================================
    logic silent_left;
    logic silent_right;
    logic cand_left;
    logic cand_right;

    vram_silence u_left (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (clk_en),
        .sample_stb  (sample_stb),
        .sample_zero (sample_left == '0),
        .dur_code    (mute_time_r[VRAM_TLEFT_MSB:VRAM_TLEFT_LSB]),
        .silent      (silent_left)
    );

    vram_silence u_right (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (clk_en),
        .sample_stb  (sample_stb),
        .sample_zero (sample_right == '0),
        .dur_code    (mute_time_r[VRAM_TRIGHT_MSB:VRAM_TRIGHT_LSB]),
        .silent      (silent_right)
    );

    assign cand_left  = silent_left && mute_ctrl_r[VRAM_EN_LEFT];
    assign cand_right = silent_right && mute_ctrl_r[VRAM_EN_RIGHT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mute_left  <= 1'b0;
            mute_right <= 1'b0;
        end else if (clk_en) begin
            if (mute_ctrl_r[VRAM_LINK]) begin
                mute_left  <= cand_left && cand_right;
                mute_right <= cand_left && cand_right;
            end else begin
                mute_left  <= cand_left;
                mute_right <= cand_right;
            end
        end
    end

    // ========================================================================
    // Emergency ramp-down.
    // ========================================================================
    typedef enum logic [1:0] {
        VRAM_IDLE = 2'b00,
        VRAM_RAMP = 2'b01,
        VRAM_HOLD = 2'b11
    } vram_state_e;

    vram_state_e state_r;
    logic [1:0]  div_r;
    logic [1:0]  speed;
    logic [3:0]  step;
    logic [2:0]  div_last;
    logic [8:0]  vol_sum;
    logic [7:0]  vol_r;

    assign speed    = emerg_r[VRAM_SPEED_MSB:VRAM_SPEED_LSB];
    assign step     = 4'h8 >> emerg_r[VRAM_STEP_MSB:VRAM_STEP_LSB];
    assign div_last = (3'h1 << speed) - 3'h1;
    assign vol_sum  = {1'b0, vol_r} + {5'h0, step};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= VRAM_IDLE;
            div_r   <= 2'h0;
            vol_r   <= VRAM_VOL_RST;
        end else if (clk_en) begin
            case (state_r)
                VRAM_IDLE: begin
                    vol_r <= normal_volume;
                    div_r <= 2'h0;
                    if (fault) begin
                        state_r <= VRAM_RAMP;
                    end
                end
                VRAM_RAMP: begin
                    if (speed == VRAM_SPEED_INSTANT) begin
                        vol_r   <= VRAM_VOL_MUTE;
                        state_r <= VRAM_HOLD;
                    end else if (sample_stb) begin
                        if ({1'b0, div_r} >= div_last) begin
                            div_r <= 2'h0;
                            if (vol_sum >= {1'b0, VRAM_VOL_MUTE}) begin
                                vol_r   <= VRAM_VOL_MUTE;
                                state_r <= VRAM_HOLD;
                            end else begin
                                vol_r <= vol_sum[7:0];
                            end
                        end else begin
                            div_r <= div_r + 2'h1;
                        end
                    end
                end
                VRAM_HOLD: begin
                    if (!fault) begin
                        state_r <= VRAM_IDLE;
                    end
                end
                default: state_r <= VRAM_IDLE;
            endcase
        end
    end

    assign volume_code      = vol_r;
    assign emergency_active = (state_r != VRAM_IDLE);

endmodule

// File: tb/vram_sample_src.sv
`timescale 1ns/100ps
module vram_sample_src #(
    parameter int PERIOD   = 4,
    parameter int SAMPLE_W = 24
)(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                zero_left,
    input  wire logic                zero_right,
    output logic                     sample_stb,
    output logic      [SAMPLE_W-1:0] sample_left,
    output logic      [SAMPLE_W-1:0] sample_right
);
    int cnt;
    int seed = 32'hDA2DB2B5;
    // ========================================================================
    // Samples are only valid with the strobe; between strobes the lines flip.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            sample_stb <= 1'b0;
            sample_left <= '0;
            sample_right <= '0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            sample_stb <= (cnt == 0);
            if (cnt == 0) begin
                sample_left <= zero_left ? '0
                             : SAMPLE_W'($random(seed)) | SAMPLE_W'(1);
                sample_right <= zero_right ? '0
                              : SAMPLE_W'($random(seed)) | SAMPLE_W'(1);
            end else begin
                sample_left <= ~sample_left;
                sample_right <= ~sample_right;
            end
        end
    end
endmodule

// File: tb/vram_top_monitor.sv
`timescale 1ns/100ps
module vram_top_monitor
    import vram_pkg::*;
#(
    parameter int SAMPLE_W = 24
)(
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                clk_en,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic [11:0]         paddr,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                sample_stb,
    input wire logic [SAMPLE_W-1:0] sample_left,
    input wire logic [SAMPLE_W-1:0] sample_right,
    input wire logic                clock_fault,
    input wire logic                power_loss,
    input wire logic [7:0]          normal_volume,
    input wire logic [7:0]          volume_code,
    input wire logic                emergency_active,
    input wire logic                mute_left,
    input wire logic                mute_right
);
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========================================================================
    // Register bus.
    sequence s_access;
        psel && penable;
    endsequence
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_unmapped_err: assert property (s_access ##0 (paddr != 12'h13C &&
        paddr != 12'h140 && paddr != 12'h144 && paddr != 12'h148) |-> pslverr)
        else $error("no error on unmapped access");
    // ========================================================================
    // Auto-mute.
    a_clear_left: assert property (
        sample_stb && clk_en && sample_left != 0 |-> ##2 !mute_left)
        else $error("left mute held after sound");
    a_clear_right: assert property (
        sample_stb && clk_en && sample_right != 0 |-> ##2 !mute_right)
        else $error("right mute held after sound");
    a_mute_cause: assert property (
        $rose(mute_left) |-> $past(sample_stb, 2))
        else $error("left mute not set by a sample");
    // ========================================================================
    // Emergency ramp.
    sequence s_fault_held;
        (clk_en && (clock_fault || power_loss)) [*5];
    endsequence
    a_fault_enter: assert property (s_fault_held |-> emergency_active)
        else $error("fault did not start ramp");
    a_ramp_down: assert property (
        emergency_active && $past(emergency_active) |->
        volume_code >= $past(volume_code) &&
        (volume_code == 8'hFF ||
         volume_code - $past(volume_code) <= 8'h08))
        else $error("bad emergency step");
    a_mute_holds: assert property (
        emergency_active && $past(emergency_active) &&
        $past(volume_code) == 8'hFF |-> volume_code == 8'hFF)
        else $error("mute not held");
    a_idle_track: assert property (
        (clk_en && !emergency_active && $stable(normal_volume)) [*3] |->
        volume_code == normal_volume)
        else $error("volume not tracking");
endmodule

bind vram_top vram_top_monitor #(.SAMPLE_W(SAMPLE_W)) vram_top_monitor_i (
    .pclk, .presetn, .clk_en, .psel, .penable, .paddr, .pready, .pslverr,
    .sample_stb, .sample_left, .sample_right, .clock_fault, .power_loss,
    .normal_volume, .volume_code, .emergency_active, .mute_left, .mute_right);

// File: tb/vram_top_tb_top.sv
`timescale 1ns/100ps
module vram_top_tb_top;
    import vram_pkg::*;
    logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
    logic        pwrite = 0, zl = 0, zr = 0, clock_fault = 0, power_loss = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, d;
    logic        pready, pslverr, er, sample_stb, emergency_active;
    logic        mute_left, mute_right;
    logic [23:0] sample_left, sample_right;
    logic [7:0]  normal_volume = 8'h30, volume_code;
    integer      seed = 32'hDA2DB2B5;
    int          n_mismatch = 0, samples_checked = 0;

    vram_top vram_top_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_stb, .sample_left,
        .sample_right, .clock_fault, .power_loss, .normal_volume, .volume_code,
        .emergency_active, .mute_left, .mute_right);
    vram_sample_src vram_sample_src_i (.pclk, .presetn, .zero_left(zl),
        .zero_right(zr), .sample_stb, .sample_left, .sample_right);

    initial forever #12.5 pclk = ~pclk;
    // ========================================================================
    // Helpers.
    task automatic stop_test;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic stbs(input int n);
        repeat (n) begin
            @(posedge pclk);
            while (sample_stb !== 1'b1) @(posedge pclk);
        end
    endtask
    function automatic int run_len(input int code);
        return VRAM_DUR_US[code] * 96 / 1000;
    endfunction
    function automatic logic [7:0] exp_vol(input logic [7:0] v,
                                           input logic [1:0] sp, st);
        int s;
        s = (sp == 2'h3) ? 255 : 8 >> st;
        return (v + s > 255) ? 8'hFF : 8'(v + s);
    endfunction
    // ========================================================================
    // A zero run broken by one nonzero sample, then a full run.
    task automatic sil(input logic [7:0] c, t, input logic l, r,
                       input int n, input logic [1:0] ex);
        apb(1, 12'h140, {24'h0, c});
        apb(1, 12'h144, {24'h0, t});
        zl <= l;
        zr <= r;
        stbs(700);
        zl <= 0;
        zr <= 0;
        stbs(1);
        zl <= l;
        zr <= r;
        stbs(n - 1);
        repeat (3) @(posedge pclk);
        check({mute_left, mute_right}, 2'b00);
        stbs(1);
        repeat (3) @(posedge pclk);
        check({mute_left, mute_right}, ex);
        apb(0, 12'h148, 0);
        check(rd[6:5], {ex[0], ex[1]});
        zl <= 0;
        zr <= 0;
        stbs(1);
        repeat (3) @(posedge pclk);
        check({mute_left, mute_right}, 2'b00);
    endtask
    task automatic emerg(input logic [1:0] sp, st);
        logic [7:0] v;
        int         k, n;
        normal_volume <= 8'hC0 | 8'($random(seed));
        apb(1, 12'h13C, {24'h0, sp, st, 4'h0});
        if (st[0]) power_loss <= 1;
        else clock_fault <= 1;
        for (k = 0; k < 9 && emergency_active !== 1'b1; k++) @(posedge pclk);
        check(emergency_active, 1);
        apb(0, 12'h148, 0);
        check(rd[7], 1);
        v = volume_code;
        n = -99;
        for (k = 0; k < 3000 && v !== 8'hFF; k++) begin
            @(posedge pclk);
            if (volume_code !== v) begin
                check(volume_code, exp_vol(v, sp, st));
                if (n >= 0) check(n, 1 << sp);
                v = volume_code;
                n = 0;
            end
            if (sample_stb === 1'b1) n++;
        end
        check(v, 8'hFF);
        clock_fault <= 0;
        power_loss <= 0;
        repeat (8) @(posedge pclk);
        check({emergency_active, volume_code}, {1'b0, normal_volume});
    endtask
    // ========================================================================
    // Main sequence.
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h13C, 0);
        check(rd, 32'h30);
        apb(0, 12'h140, 0);
        check(rd, 32'h07);
        apb(0, 12'h144, 0);
        check(rd, 32'h00);
        apb(0, 12'h200, 0);
        check(er, 1);
        check(rd, 32'h0);
        d = $random(seed);
        apb(1, 12'h13C, d);
        apb(0, 12'h13C, 0);
        check(rd, d & 32'hF0);
        apb(1, 12'h144, d);
        clk_en <= 0;
        apb(1, 12'h144, 0);
        clk_en <= 1;
        apb(0, 12'h144, 0);
        check(rd, d & 32'h77);
        apb(1, 12'h140, d);
        apb(0, 12'h140, 0);
        check(rd, d & 32'h07);
        for (int i = 0; i < 16; i++) emerg(2'(i >> 2), 2'(i));
        sil(8'h03, 8'h00, 1, 0, run_len(0), 2'b10);
        sil(8'h07, 8'h00, 1, 0, run_len(0), 2'b00);
        sil(8'h07, 8'h00, 1, 1, run_len(0), 2'b11);
        sil(8'h02, 8'h01, 1, 1, run_len(1), 2'b01);
        stop_test;
    end
    initial begin
        repeat (100000) @(posedge pclk);
        n_mismatch++;
        stop_test;
    end
endmodule
